// *** rtl/ascfg_top.sv ***
// Sequence configuration registers plus a small slot walker for the converter.
// Assumes a single-cycle register port and an engine that pulses start and next.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "ascfg_defs.svh"
module ascfg_top
    import ascfg_pkg::*;
#(
    parameter int REG_SLOTS = 16,
    parameter int INS_SLOTS = 4
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [31:0] reg_rdata,
    input  wire logic        seq_start_regular,
    input  wire logic        seq_start_inserted,
    input  wire logic        seq_next,
    output      logic        seq_busy,
    output      logic        seq_inserted,
    output      logic [4:0]  seq_channel,
    output      logic        seq_last,
    output      logic [11:0] awd_low_limit,
    output      logic [3:0]  regular_group_length,
    output      logic [1:0]  inserted_group_length,
    output      logic [79:0] regular_slot_channel,
    output      logic [19:0] inserted_slot_channel
);
    logic [31:0]  watchdog_low_limit_reg;
    logic [31:0]  regular_sequence_upper_reg;
    logic [31:0]  regular_sequence_middle_reg;
    logic [31:0]  regular_sequence_lower_reg;
    logic [31:0]  inserted_sequence_reg;
    ascfg_state_t state_reg;
    ascfg_state_t state_next;
    logic [3:0]   pos_reg;
    logic [3:0]   pos_next;
    logic [4:0]   reg_pick;
    logic [4:0]   ins_pick;
    logic [1:0]   ins_index;

    // Masks a write so reserved bits stay zero even if software misbehaves.
    function automatic logic [31:0] wr_mask(input logic [7:0] addr);
        case (addr)
            `ASCFG_OFF_WDLOW:    wr_mask = `ASCFG_AWD_MASK;
            `ASCFG_OFF_RSEQ_UP:  wr_mask = `ASCFG_UP_MASK;
            `ASCFG_OFF_RSEQ_MID: wr_mask = `ASCFG_MID_MASK;
            `ASCFG_OFF_RSEQ_LOW: wr_mask = `ASCFG_MID_MASK;
            `ASCFG_OFF_ISEQ:     wr_mask = `ASCFG_ISEQ_MASK;
            default:             wr_mask = `ASCFG_RESET_WORD;
        endcase
    endfunction

    // Watchdog low limit register.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_low_limit_reg <= `ASCFG_RESET_WORD;
        end else if (reg_wr && reg_addr == `ASCFG_OFF_WDLOW) begin
            watchdog_low_limit_reg <= reg_wdata & wr_mask(reg_addr);
        end
    end

    // Regular sequence registers; the byte lanes are not split since only word writes exist.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regular_sequence_upper_reg  <= `ASCFG_RESET_WORD;
            regular_sequence_middle_reg <= `ASCFG_RESET_WORD;
            regular_sequence_lower_reg  <= `ASCFG_RESET_WORD;
        end else if (reg_wr) begin
            if (reg_addr == `ASCFG_OFF_RSEQ_UP) begin
                regular_sequence_upper_reg <= reg_wdata & wr_mask(reg_addr);
            end
            if (reg_addr == `ASCFG_OFF_RSEQ_MID) begin
                regular_sequence_middle_reg <= reg_wdata & wr_mask(reg_addr);
            end
            if (reg_addr == `ASCFG_OFF_RSEQ_LOW) begin
                regular_sequence_lower_reg <= reg_wdata & wr_mask(reg_addr);
            end
        end
    end

    // Inserted sequence register.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inserted_sequence_reg <= `ASCFG_RESET_WORD;
        end else if (reg_wr && reg_addr == `ASCFG_OFF_ISEQ) begin
            inserted_sequence_reg <= reg_wdata & wr_mask(reg_addr);
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `ASCFG_RESET_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `ASCFG_OFF_WDLOW:    reg_rdata <= watchdog_low_limit_reg;
                `ASCFG_OFF_RSEQ_UP:  reg_rdata <= regular_sequence_upper_reg;
                `ASCFG_OFF_RSEQ_MID: reg_rdata <= regular_sequence_middle_reg;
                `ASCFG_OFF_RSEQ_LOW: reg_rdata <= regular_sequence_lower_reg;
                `ASCFG_OFF_ISEQ:     reg_rdata <= inserted_sequence_reg;
                default:             reg_rdata <= `ASCFG_RESET_WORD;
            endcase
        end else begin
            reg_rdata <= `ASCFG_RESET_WORD;
        end
    end

    // Field views for the engine: slot 0 sits in the low register, slot 15 in the upper.
    assign awd_low_limit         = watchdog_low_limit_reg[`ASCFG_AWD_MSB:0];
    assign regular_group_length  = regular_sequence_upper_reg[`ASCFG_RLEN_MSB:`ASCFG_RLEN_LSB];
    assign inserted_group_length = inserted_sequence_reg[`ASCFG_ILEN_MSB:`ASCFG_ILEN_LSB];
    assign regular_slot_channel  = {regular_sequence_upper_reg[`ASCFG_UP_SLOT_MSB:0],
                                    regular_sequence_middle_reg[`ASCFG_MID_SLOT_MSB:0],
                                    regular_sequence_lower_reg[`ASCFG_MID_SLOT_MSB:0]};
    assign inserted_slot_channel = inserted_sequence_reg[`ASCFG_ISLOT_MSB:0];

    // Channel lookup for both groups, indexed by the slot the walker moves to next.
    // Looking ahead costs a mux on the comb path but lets the registered channel
    // follow an advance with no extra cycle of latency.
    ascfg_slot_pick #(.SLOTS(REG_SLOTS), .IDX_W(`ASCFG_RIDX_W)) u_reg_pick (
        .slots   (regular_slot_channel),
        .index   (pos_next),
        .channel (reg_pick)
    );
    assign ins_index = pos_next[1:0];
    ascfg_slot_pick #(.SLOTS(INS_SLOTS), .IDX_W(`ASCFG_IIDX_W)) u_ins_pick (
        .slots   (inserted_slot_channel),
        .index   (ins_index),
        .channel (ins_pick)
    );

    // Walker: inserted start takes priority over regular start when both pulse together.
    always_comb begin
        state_next = state_reg;
        pos_next   = pos_reg;
        case (state_reg)
            ASCFG_IDLE: begin
                if (seq_start_inserted) begin
                    state_next = ASCFG_INSERT;
                    pos_next   = {2'b00, `ASCFG_ISLOT_LAST - inserted_group_length};
                end else if (seq_start_regular) begin
                    state_next = ASCFG_REGULAR;
                    pos_next   = 4'h0;
                end
            end
            ASCFG_REGULAR: begin
                if (seq_next) begin
                    if (pos_reg == regular_group_length) begin
                        state_next = ASCFG_IDLE;
                        pos_next   = 4'h0;
                    end else begin
                        pos_next = pos_reg + 4'h1;
                    end
                end
            end
            ASCFG_INSERT: begin
                if (seq_next) begin
                    if (pos_reg[1:0] == `ASCFG_ISLOT_LAST) begin
                        state_next = ASCFG_IDLE;
                        pos_next   = 4'h0;
                    end else begin
                        pos_next = pos_reg + 4'h1;
                    end
                end
            end
            default: begin
                state_next = ASCFG_IDLE;
                pos_next   = 4'h0;
            end
        endcase
    end

    // Walker state.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ASCFG_IDLE;
            pos_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            pos_reg   <= pos_next;
        end
    end

    // Channel output registered so the engine sees a stable value.
    // A limitation: a slot rewritten during a walk reaches the channel one cycle
    // after the write lands, since the view is refreshed on every clock.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_channel <= 5'h00;
            seq_last    <= 1'b0;
        end else if (state_next == ASCFG_INSERT) begin
            seq_channel <= ins_pick;
            seq_last    <= (ins_index == `ASCFG_ISLOT_LAST);
        end else if (state_next == ASCFG_REGULAR) begin
            seq_channel <= reg_pick;
            seq_last    <= (pos_next == regular_group_length);
        end else begin
            seq_channel <= 5'h00;
            seq_last    <= 1'b0;
        end
    end

    // Status levels come straight from the state register, so they never glitch
    // on the start or advance pulses.
    assign seq_busy     = (state_reg != ASCFG_IDLE);
    assign seq_inserted = (state_reg == ASCFG_INSERT);
endmodule

// *** rtl/ascfg_defs.svh ***
// Constants for the converter sequence configuration block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef ASCFG_DEFS_SVH
`define ASCFG_DEFS_SVH
`define ASCFG_OFF_WDLOW      8'h28
`define ASCFG_OFF_RSEQ_UP    8'h2c
`define ASCFG_OFF_RSEQ_MID   8'h30
`define ASCFG_OFF_RSEQ_LOW   8'h34
`define ASCFG_OFF_ISEQ       8'h38
`define ASCFG_RESET_WORD     32'h0000_0000
`define ASCFG_AWD_MSB        11
`define ASCFG_RLEN_LSB       20
`define ASCFG_RLEN_MSB       23
`define ASCFG_ILEN_LSB       20
`define ASCFG_ILEN_MSB       21
`define ASCFG_SLOT_W         5
`define ASCFG_UP_MASK        32'h00ff_ffff
`define ASCFG_MID_MASK       32'h3fff_ffff
`define ASCFG_ISEQ_MASK      32'h003f_ffff
`define ASCFG_AWD_MASK       32'h0000_0fff
`define ASCFG_ISLOT_LAST     2'h3
`define ASCFG_UP_SLOT_MSB    19
`define ASCFG_MID_SLOT_MSB   29
`define ASCFG_ISLOT_MSB      19
`define ASCFG_RIDX_W         4
`define ASCFG_IIDX_W         2
`endif

// *** rtl/ascfg_pkg.sv ***
// Types shared by the sequence configuration block.
// Assumes the defines header is compiled with it.
package ascfg_pkg;
    typedef enum logic [1:0] {
        ASCFG_IDLE    = 2'b00,
        ASCFG_REGULAR = 2'b01,
        ASCFG_INSERT  = 2'b10
    } ascfg_state_t;
endpackage

// *** rtl/ascfg_slot_pick.sv ***
// Slot selector: picks one 5-bit channel out of a packed slot vector.
// Assumes the index is in range of the slot count.
`timescale 1ns/1ns
`include "ascfg_defs.svh"
module ascfg_slot_pick
    import ascfg_pkg::*;
#(
    parameter int SLOTS = 16,
    parameter int IDX_W = 4
) (
    input  wire logic [SLOTS*`ASCFG_SLOT_W-1:0] slots,
    input  wire logic [IDX_W-1:0]              index,
    output      logic [`ASCFG_SLOT_W-1:0]      channel
);
    // Indexed part-select keeps the mux a single level of logic.
    assign channel = slots[index*`ASCFG_SLOT_W +: `ASCFG_SLOT_W];
endmodule

// *** testbench/ascfg_top_monitor.sv ***
// Port-level checker for the sequence configuration block.
// Assumes a single clock domain; bound to the top module at the foot.
`timescale 1ns/1ns
module ascfg_top_monitor (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        seq_start_regular,
    input wire logic        seq_start_inserted,
    input wire logic        seq_next,
    input wire logic        seq_busy,
    input wire logic        seq_inserted,
    input wire logic [4:0]  seq_channel,
    input wire logic        seq_last,
    input wire logic [11:0] awd_low_limit,
    input wire logic [3:0]  regular_group_length,
    input wire logic [1:0]  inserted_group_length,
    input wire logic [79:0] regular_slot_channel,
    input wire logic [19:0] inserted_slot_channel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Writes reach the field outputs one cycle after the strobe.
    a_awd_write: assert property (reg_wr && reg_addr == 8'h28 |=> awd_low_limit == $past(reg_wdata[11:0]))
        else $error("low limit missed a write");
    a_rlen_write: assert property (reg_wr && reg_addr == 8'h2c |=> regular_group_length == $past(reg_wdata[23:20]))
        else $error("regular length missed a write");
    a_ins_write: assert property (reg_wr && reg_addr == 8'h38 |=>
        {inserted_group_length, inserted_slot_channel} == $past(reg_wdata[21:0])) else $error("inserted word missed a write");
    // Read data stand only in the cycle after the read strobe.
    a_rd_awd: assert property (reg_rd && reg_addr == 8'h28 |=> reg_rdata == {20'h0, $past(awd_low_limit)})
        else $error("low limit read back wrong");
    a_rdata_idle: assert property ($past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0) else $error("read data outside read slot");
    // A walk opens on its first slot; the inserted group opens at three minus length.
    a_reg_start: assert property (seq_start_regular && !seq_start_inserted && !seq_busy |=> seq_busy && !seq_inserted
        && seq_channel == $past(regular_slot_channel[4:0]) && seq_last == ($past(regular_group_length) == 4'h0))
        else $error("regular walk opened wrong");
    a_ins_start: assert property (seq_start_inserted && !seq_busy |=> seq_busy && seq_inserted
        && seq_channel == 5'($past(inserted_slot_channel) >> (5 * (3 - $past(inserted_group_length)))))
        else $error("inserted walk opened wrong");
    a_group_end: assert property (seq_busy && seq_last && seq_next |=> !seq_busy && seq_channel == 5'h0)
        else $error("walk did not end after last slot");
    a_ins_last: assert property (seq_busy && seq_inserted && seq_last |-> seq_channel == inserted_slot_channel[19:15])
        else $error("inserted walk did not end at slot three");
    c_reg_walk: cover property (seq_start_regular && !seq_busy);
    c_ins_walk: cover property (seq_start_inserted && !seq_busy);
    c_read: cover property (reg_rd && reg_addr == 8'h38);
endmodule
bind ascfg_top ascfg_top_monitor u_ascfg_top_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seq_start_regular(seq_start_regular), .seq_start_inserted(seq_start_inserted), .seq_next(seq_next),
    .seq_busy(seq_busy), .seq_inserted(seq_inserted), .seq_channel(seq_channel), .seq_last(seq_last),
    .awd_low_limit(awd_low_limit), .regular_group_length(regular_group_length),
    .inserted_group_length(inserted_group_length), .regular_slot_channel(regular_slot_channel),
    .inserted_slot_channel(inserted_slot_channel));

// *** testbench/ascfg_top_tb.sv ***
// Self-checking bench for the sequence configuration block.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ns
`include "ascfg_defs.svh"
module ascfg_top_tb;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, seq_start_regular, seq_start_inserted, seq_next;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        seq_busy, seq_inserted, seq_last;
    logic [4:0]  seq_channel;
    logic [11:0] awd_low_limit;
    logic [3:0]  regular_group_length;
    logic [1:0]  inserted_group_length;
    logic [79:0] regular_slot_channel;
    logic [19:0] inserted_slot_channel;
    logic [31:0] mreg [5];
    int          miscompares = 0;
    int          checked = 0;
    // Writable bits of each register; reserved positions never reach the model.
    localparam logic [31:0] MASK [5] = '{`ASCFG_AWD_MASK, `ASCFG_UP_MASK, `ASCFG_MID_MASK, `ASCFG_MID_MASK,
                                         `ASCFG_ISEQ_MASK};
    wire [79:0] mslots = {mreg[1][19:0], mreg[2][29:0], mreg[3][29:0]};
    ascfg_top u_ascfg_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_start_regular(seq_start_regular),
        .seq_start_inserted(seq_start_inserted), .seq_next(seq_next), .seq_busy(seq_busy),
        .seq_inserted(seq_inserted), .seq_channel(seq_channel), .seq_last(seq_last), .awd_low_limit(awd_low_limit),
        .regular_group_length(regular_group_length), .inserted_group_length(inserted_group_length),
        .regular_slot_channel(regular_slot_channel), .inserted_slot_channel(inserted_slot_channel));
    // Free-running clock at 50 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [99:0] got, input logic [99:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Six channel slots in the range the converter accepts, packed as one word.
    function automatic logic [31:0] slots6();
        logic [31:0] w = 32'h0;
        for (int i = 0; i < 6; i++) w[5 * i +: 5] = 5'($urandom_range(17));
        return w;
    endfunction
    // Word write; unmapped offsets leave the model untouched.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a >= 8'h28 && a <= 8'h38) mreg[(a - 8'h28) / 4] = d & MASK[(a - 8'h28) / 4];
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, (a >= 8'h28 && a <= 8'h38) ? mreg[(a - 8'h28) / 4] : 32'h0);
    endtask
    // One walk; a start is also tried mid-walk, which the block must refuse.
    task automatic walk(input bit ins);
        int first;
        int n;
        logic [4:0] ec;
        first = ins ? 3 - int'(mreg[4][21:20]) : 0;
        n = ins ? int'(mreg[4][21:20]) + 1 : int'(mreg[1][23:20]) + 1;
        @(posedge ref_clk);
        seq_start_inserted <= ins;
        seq_start_regular <= !ins;
        @(posedge ref_clk);
        seq_start_inserted <= 1'b0;
        seq_start_regular <= 1'b0;
        for (int k = 0; k < n; k++) begin
            ec = ins ? 5'(mreg[4] >> (5 * (first + k))) : 5'(mslots >> (5 * k));
            #1 chk({seq_busy, seq_inserted, seq_last, seq_channel}, {1'b1, ins, k == n - 1, ec});
            @(posedge ref_clk);
            seq_next <= 1'b1;
            seq_start_inserted <= (k == 0) && !ins;
            seq_start_regular <= (k == 0) && ins;
            @(posedge ref_clk);
            seq_next <= 1'b0;
            seq_start_inserted <= 1'b0;
            seq_start_regular <= 1'b0;
        end
        #1 chk({seq_busy, seq_channel}, 6'h0);
    endtask
    // Hang guard: a run this long counts as a failure.
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
    // Reset values, then every regular length and every inserted length code.
    initial begin
        {sys_rst, reg_wr, reg_rd, seq_start_regular, seq_start_inserted, seq_next} = 6'b100000;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        for (int i = 0; i < 5; i++) mreg[i] = 32'h0;
        void'($urandom(5));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(8'(8'h28 + 4 * i));
        for (int l = 0; l < 16; l++) begin
            wr(8'h28, 32'($urandom_range(4095)));
            wr(8'h34, slots6());
            wr(8'h30, slots6());
            wr(8'h2c, (slots6() & 32'h000f_ffff) | (32'(l) << 20));
            wr(8'h38, (slots6() & 32'h000f_ffff) | (32'(l % 4) << 20));
            wr(8'h3c, $urandom());
            #1 chk(awd_low_limit, mreg[0][11:0]);
            chk({regular_group_length, inserted_group_length}, {mreg[1][23:20], mreg[4][21:20]});
            chk({regular_slot_channel, inserted_slot_channel}, {mslots, mreg[4][19:0]});
            for (int i = 0; i < 6; i++) rd(8'(8'h28 + 4 * i));
            walk(1'b0);
            walk(1'b1);
        end
        print_verdict();
    end
endmodule
